// file: ebtcm_timer.sv
// Timer core: clock-select and mode-control registers, counter, compare and output
`timescale 1ns/1ps
`default_nettype none

module ebtcm_timer
    import ebtcm_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic [15:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_BIT_WR,
    input wire logic [2:0] I_BIT_SEL,
    input wire logic I_BIT_VAL,
    input wire logic [7:0] I_WDATA,
    input wire logic I_RD,
    input wire logic I_OSC_MODE,
    input wire logic [7:0] I_COMPARE_VALUE,
    input wire logic I_EXT_COUNT_PIN,
    output logic [7:0] O_RDATA,
    output logic [7:0] O_COUNT_VALUE,
    output logic O_MATCH_IRQ,
    output logic O_TIMER_OUT,
    output logic O_TIMER_OE
);

    typedef struct packed {
        logic [7:0] clk_sel;
        logic [7:0] mode_ctl;
        logic [7:0] count;
        logic out_ff;
        logic irq;
        logic pin_val;
        logic pin_oe;
        logic [7:0] rdata;
    } ebtcm_state_t;

    ebtcm_state_t st_ff;
    ebtcm_state_t nxt_st;
    logic tick;

    // ************************************************************
    // Count clock
    // ************************************************************
    ebtcm_prescaler u_prescaler (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N),
        .i_code(st_ff.clk_sel[3:0]),
        .i_osc_full(I_OSC_MODE),
        .i_ext_pin(I_EXT_COUNT_PIN),
        .o_tick(tick)
    );

    // ************************************************************
    // Registers, counter and output
    // ************************************************************
    always_comb begin
        logic mode_hit;
        logic [7:0] wr_byte;
        logic [1:0] ff_cmd;
        logic match;
        logic pwm_act;
        logic ext_sel;
        mode_hit = (I_ADDR == ADDR_MODE_CTL);
        wr_byte = st_ff.mode_ctl;
        ff_cmd = FF_KEEP;
        match = (st_ff.count == I_COMPARE_VALUE);
        pwm_act = st_ff.mode_ctl[BIT_COUNT_EN] && (st_ff.count < I_COMPARE_VALUE);
        ext_sel = code_is_ext(st_ff.clk_sel[3:0]);
        nxt_st = st_ff;
        nxt_st.irq = 1'b0;

        // Byte writes to clock select only; bit writes there are ignored
        if (I_WR && (I_ADDR == ADDR_CLK_SEL)) begin
            nxt_st.clk_sel = I_WDATA & CLK_SEL_MASK;
        end

        // A bit write merges into the readback value, so set/reset act only if named
        if (mode_hit && I_WR) begin
            wr_byte = I_WDATA;
        end else if (mode_hit && I_BIT_WR) begin
            wr_byte[I_BIT_SEL] = I_BIT_VAL;
        end
        if (mode_hit && (I_WR || I_BIT_WR)) begin
            nxt_st.mode_ctl = wr_byte & MODE_STORED_MASK;
            ff_cmd = {wr_byte[BIT_FF_SET], wr_byte[BIT_FF_RESET]};
        end

        // Counter
        if (!st_ff.mode_ctl[BIT_COUNT_EN]) begin
            nxt_st.count = COUNT_ZERO;
        end else if (tick) begin
            if (match) begin
                nxt_st.irq = 1'b1;
            end
            if (match && !st_ff.mode_ctl[BIT_PWM_MODE]) begin
                nxt_st.count = COUNT_ZERO;
                if (st_ff.mode_ctl[BIT_LEVEL_INV]) begin
                    nxt_st.out_ff = !st_ff.out_ff;
                end
            end else begin
                nxt_st.count = 8'(st_ff.count + COUNT_ONE);
            end
        end

        // Software command wins over a same-cycle toggle; code 11 does nothing
        if (ff_cmd == FF_PRESET) begin
            nxt_st.out_ff = 1'b1;
        end else if (ff_cmd == FF_CLEAR) begin
            nxt_st.out_ff = 1'b0;
        end

        // Pin shares the external count input, so no drive while counting edges
        nxt_st.pin_oe = st_ff.mode_ctl[BIT_OUT_GATE] && !ext_sel;
        if (!nxt_st.pin_oe) begin
            nxt_st.pin_val = 1'b0;
        end else if (st_ff.mode_ctl[BIT_PWM_MODE]) begin
            nxt_st.pin_val = pwm_act ^ st_ff.mode_ctl[BIT_LEVEL_INV];
        end else begin
            nxt_st.pin_val = st_ff.out_ff;
        end

        // Read port
        nxt_st.rdata = RDATA_IDLE;
        if (I_RD && mode_hit) begin
            nxt_st.rdata = st_ff.mode_ctl;
        end else if (I_RD && (I_ADDR == ADDR_CLK_SEL)) begin
            nxt_st.rdata = st_ff.clk_sel;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            st_ff.clk_sel <= CLK_SEL_RESET;
            st_ff.mode_ctl <= MODE_CTL_RESET;
            st_ff.count <= COUNT_ZERO;
            st_ff.out_ff <= 1'b0;
            st_ff.irq <= 1'b0;
            st_ff.pin_val <= 1'b0;
            st_ff.pin_oe <= 1'b0;
            st_ff.rdata <= RDATA_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_RDATA = st_ff.rdata;
    assign O_COUNT_VALUE = st_ff.count;
    assign O_MATCH_IRQ = st_ff.irq;
    assign O_TIMER_OUT = st_ff.pin_val;
    assign O_TIMER_OE = st_ff.pin_oe;

    // ************************************************************
    // Checks
    // ************************************************************
    a_clksel_upper_zero:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_WR && I_ADDR == ADDR_CLK_SEL) |=> (st_ff.clk_sel == (CLK_SEL_MASK & $past(I_WDATA))))
        else $error("clock select did not store the low nibble only");

    a_setreset_read_zero:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_RD && I_ADDR == ADDR_MODE_CTL) |=> !O_RDATA[BIT_FF_SET] && !O_RDATA[BIT_FF_RESET])
        else $error("set or reset bit read back as one");

    a_stop_clears_count:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !st_ff.mode_ctl[BIT_COUNT_EN] |=> (O_COUNT_VALUE == COUNT_ZERO))
        else $error("stopped counter not cleared");

    a_match_irq:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_COUNT_EN] && tick && st_ff.count == I_COMPARE_VALUE)
        |=> O_MATCH_IRQ)
        else $error("compare match raised no interrupt");

    a_clear_on_match:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_COUNT_EN] && !st_ff.mode_ctl[BIT_PWM_MODE] && tick
         && st_ff.count == I_COMPARE_VALUE) |=> (O_COUNT_VALUE == COUNT_ZERO))
        else $error("clear-and-start mode did not restart on match");

    a_pwm_free_run:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_COUNT_EN] && st_ff.mode_ctl[BIT_PWM_MODE] && tick
         && !(I_WR || I_BIT_WR))
        |=> (O_COUNT_VALUE == 8'($past(O_COUNT_VALUE) + COUNT_ONE)))
        else $error("PWM counter did not free-run");

    a_no_advance_illegal:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (!code_is_legal(st_ff.clk_sel[3:0], I_OSC_MODE) && !(I_WR || I_BIT_WR)) [*2]
        |=> $stable(O_COUNT_VALUE))
        else $error("counter advanced on a prohibited clock code");

    a_ff_set:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_WR && I_ADDR == ADDR_MODE_CTL && I_WDATA[BIT_FF_SET] && !I_WDATA[BIT_FF_RESET])
        |=> st_ff.out_ff ##1 (O_TIMER_OUT || !O_TIMER_OE || st_ff.mode_ctl[BIT_PWM_MODE]))
        else $error("set command did not set the output flip-flop");

    a_ff_reset:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_WR && I_ADDR == ADDR_MODE_CTL && !I_WDATA[BIT_FF_SET] && I_WDATA[BIT_FF_RESET])
        |=> !st_ff.out_ff)
        else $error("reset command did not clear the output flip-flop");

    a_ext_no_output:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        code_is_ext(st_ff.clk_sel[3:0]) |=> !O_TIMER_OE)
        else $error("timer output driven while clocked from pin");

    a_gate_off:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !st_ff.mode_ctl[BIT_OUT_GATE] |=> !O_TIMER_OE && !O_TIMER_OUT)
        else $error("timer output driven while gated off");

    a_clksel_hold:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !(I_WR && I_ADDR == ADDR_CLK_SEL) |=> $stable(st_ff.clk_sel))
        else $error("clock select changed without a byte write");

    a_clksel_read:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_RD && I_ADDR == ADDR_CLK_SEL)
        |=> (O_RDATA == $past(st_ff.clk_sel)) && ((O_RDATA & ~CLK_SEL_MASK) == RDATA_IDLE))
        else $error("clock select read back wrong");

    a_mode_unused_zero:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl & ~MODE_STORED_MASK) == RDATA_IDLE)
        else $error("unstored mode bits held a one");

    a_mode_byte_write:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_WR && I_ADDR == ADDR_MODE_CTL)
        |=> st_ff.mode_ctl == (MODE_STORED_MASK & $past(I_WDATA)))
        else $error("mode byte write not stored");

    a_mode_bit_write:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_BIT_WR && !I_WR && I_ADDR == ADDR_MODE_CTL && I_BIT_SEL == 3'(BIT_OUT_GATE))
        |=> st_ff.mode_ctl[BIT_OUT_GATE] == $past(I_BIT_VAL))
        else $error("mode bit write not stored");

    a_mode_read:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_RD && I_ADDR == ADDR_MODE_CTL) |=> O_RDATA == $past(st_ff.mode_ctl))
        else $error("mode register read back wrong");

    a_count_hold:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_COUNT_EN] && !tick) |=> $stable(O_COUNT_VALUE))
        else $error("counter moved without a count clock");

    a_clear_mode_step:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_COUNT_EN] && !st_ff.mode_ctl[BIT_PWM_MODE] && tick
         && st_ff.count != I_COMPARE_VALUE)
        |=> (O_COUNT_VALUE == 8'($past(O_COUNT_VALUE) + COUNT_ONE)))
        else $error("clear-and-start counter did not step");

    a_irq_needs_tick:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !(st_ff.mode_ctl[BIT_COUNT_EN] && tick && st_ff.count == I_COMPARE_VALUE)
        |=> !O_MATCH_IRQ)
        else $error("interrupt without a counted match");

    a_ff_prohibited:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (I_WR && I_ADDR == ADDR_MODE_CTL && I_WDATA[BIT_FF_SET] && I_WDATA[BIT_FF_RESET]
         && !st_ff.mode_ctl[BIT_LEVEL_INV]) |=> $stable(st_ff.out_ff))
        else $error("prohibited set/reset code moved the flip-flop");

    a_no_invert_hold:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (!st_ff.mode_ctl[BIT_LEVEL_INV] && !(I_WR || I_BIT_WR)) |=> $stable(st_ff.out_ff))
        else $error("flip-flop toggled with inversion disabled");

    a_invert_on_match:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_COUNT_EN] && !st_ff.mode_ctl[BIT_PWM_MODE]
         && st_ff.mode_ctl[BIT_LEVEL_INV] && tick && st_ff.count == I_COMPARE_VALUE
         && !(I_WR || I_BIT_WR)) |=> st_ff.out_ff != $past(st_ff.out_ff))
        else $error("flip-flop not inverted on match");

    a_pin_follows_ff:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_OUT_GATE] && !st_ff.mode_ctl[BIT_PWM_MODE]
         && !code_is_ext(st_ff.clk_sel[3:0]))
        |=> O_TIMER_OE && (O_TIMER_OUT == $past(st_ff.out_ff)))
        else $error("pin does not show the flip-flop");

    // Active phase is count below compare, so compare 00 keeps the pin inactive
    a_pwm_active:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_OUT_GATE] && st_ff.mode_ctl[BIT_PWM_MODE]
         && !code_is_ext(st_ff.clk_sel[3:0]) && st_ff.mode_ctl[BIT_COUNT_EN]
         && st_ff.count < I_COMPARE_VALUE)
        |=> O_TIMER_OUT != $past(st_ff.mode_ctl[BIT_LEVEL_INV]))
        else $error("PWM pin not at active level");

    a_pwm_inactive:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        (st_ff.mode_ctl[BIT_OUT_GATE] && st_ff.mode_ctl[BIT_PWM_MODE]
         && !code_is_ext(st_ff.clk_sel[3:0])
         && !(st_ff.mode_ctl[BIT_COUNT_EN] && st_ff.count < I_COMPARE_VALUE))
        |=> O_TIMER_OUT == $past(st_ff.mode_ctl[BIT_LEVEL_INV]))
        else $error("PWM pin not at inactive level");

endmodule : ebtcm_timer

`default_nettype wire

// file: ebtcm_pkg.sv
// Package with register map, field layout, clock-select codes and decode functions
package ebtcm_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] ADDR_MODE_CTL = 16'hFF53;
    localparam logic [15:0] ADDR_CLK_SEL = 16'hFF56;
    localparam logic [7:0] MODE_CTL_RESET = 8'h00;
    localparam logic [7:0] CLK_SEL_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int BIT_COUNT_EN = 7;
    localparam int BIT_PWM_MODE = 6;
    localparam int BIT_FF_SET = 3;
    localparam int BIT_FF_RESET = 2;
    localparam int BIT_LEVEL_INV = 1;
    localparam int BIT_OUT_GATE = 0;
    // Bits 5, 4, 3 and 2 of the mode register are never stored
    localparam logic [7:0] MODE_STORED_MASK = 8'hC3;
    localparam logic [7:0] CLK_SEL_MASK = 8'h0F;
    localparam logic [1:0] FF_KEEP = 2'b00;
    localparam logic [1:0] FF_CLEAR = 2'b01;
    localparam logic [1:0] FF_PRESET = 2'b10;

    // ************************************************************
    // Count-clock selection codes
    // ************************************************************
    localparam logic [3:0] CODE_EXT_FALL = 4'h0;
    localparam logic [3:0] CODE_EXT_RISE = 4'h1;
    localparam logic [3:0] CODE_2FXX = 4'h4;
    localparam logic [3:0] CODE_FXX = 4'h5;
    localparam logic [3:0] CODE_LAST = 4'hF;
    localparam logic [3:0] EXP_LAST = 4'hB;
    localparam logic [3:0] EXP_ZERO = 4'h0;
    localparam logic [3:0] EXP_ONE = 4'h1;
    localparam int DIV_W = 12;
    localparam logic [DIV_W-1:0] DIV_ONE = 12'h001;

    // ************************************************************
    // Counter constants
    // ************************************************************
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [7:0] COUNT_MAX = 8'hFF;

    function automatic logic code_is_ext(input logic [3:0] code);
        return (code == CODE_EXT_FALL) || (code == CODE_EXT_RISE);
    endfunction : code_is_ext

    function automatic logic code_is_legal(input logic [3:0] code, input logic osc_full);
        return code_is_ext(code) || ((code == CODE_2FXX) && !osc_full) || (code >= CODE_FXX);
    endfunction : code_is_legal

    // Exponent of the divider from the oscillator clock down to the count clock
    function automatic logic [3:0] div_exponent(input logic [3:0] code, input logic osc_full);
        logic [3:0] base;
        base = EXP_ZERO;
        if (code == CODE_LAST) begin
            base = EXP_LAST;
        end else if (code >= CODE_FXX) begin
            base = 4'(code - CODE_FXX);
        end
        if (code == CODE_2FXX) begin
            return EXP_ZERO;
        end
        return osc_full ? base : 4'(base + EXP_ONE);
    endfunction : div_exponent

endpackage : ebtcm_pkg

// file: ebtcm_prescaler.sv
// Count-clock selector: prescaled oscillator or external pin edges
`timescale 1ns/1ps
`default_nettype none

module ebtcm_prescaler
    import ebtcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_code,
    input wire logic i_osc_full,
    input wire logic i_ext_pin,
    output logic o_tick
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [DIV_W-1:0] div;
        logic tick;
    } ebtcm_presc_t;

    ebtcm_presc_t st_ff;
    ebtcm_presc_t nxt_st;

    // ************************************************************
    // Tick generation
    // ************************************************************
    always_comb begin
        logic [DIV_W-1:0] mask;
        logic rise;
        logic fall;
        mask = 12'((DIV_ONE << div_exponent(i_code, i_osc_full)) - DIV_ONE);
        rise = st_ff.sync2 && !st_ff.prev;
        fall = !st_ff.sync2 && st_ff.prev;
        nxt_st = st_ff;
        nxt_st.sync1 = i_ext_pin;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev = st_ff.sync2;
        nxt_st.div = 12'(st_ff.div + DIV_ONE);
        if (!code_is_legal(i_code, i_osc_full)) begin
            nxt_st.tick = 1'b0;
        end else if (i_code == CODE_EXT_FALL) begin
            nxt_st.tick = fall;
        end else if (i_code == CODE_EXT_RISE) begin
            nxt_st.tick = rise;
        end else begin
            nxt_st.tick = ((st_ff.div & mask) == mask);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_tick = st_ff.tick;

    // ************************************************************
    // Checks
    // ************************************************************
    a_double_rate:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_code == CODE_2FXX && !i_osc_full) [*2] |=> o_tick)
        else $error("double-rate code must tick every cycle");

    a_half_rate:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_code == CODE_FXX && !i_osc_full && $stable(i_code) && $stable(i_osc_full)
         && o_tick) |=> !o_tick)
        else $error("half oscillator rate ticked twice in a row");

    a_ext_rise:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_code == CODE_EXT_RISE && st_ff.sync2 && !st_ff.prev) |=> o_tick)
        else $error("rising pin edge not counted");

    a_illegal_quiet:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !code_is_legal(i_code, i_osc_full) |=> !o_tick)
        else $error("prohibited code produced a tick");

endmodule : ebtcm_prescaler

`default_nettype wire

// file: ebtcm_pin_model.sv
// External count source and the shared timer pin as seen from outside the device
`timescale 1ns/1ps
`default_nettype none

module ebtcm_pin_model (
    input wire logic i_clk,
    input wire logic i_oe,
    input wire logic i_out,
    output logic o_ext,
    output logic o_wire
);
    // The source holds its line low between bursts, as a pulled-down line would
    initial o_ext = 1'b0;

    // Shared pin: the timer owns it only in output mode, otherwise the source does
    assign o_wire = i_oe ? i_out : o_ext;

    // Each pulse is one rising and one falling edge, so either edge code counts n
    task automatic pulse(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge i_clk);
            #2 o_ext = 1'b1;
            repeat (half) @(posedge i_clk);
            #2 o_ext = 1'b0;
        end
    endtask : pulse
endmodule : ebtcm_pin_model

`default_nettype wire

// file: ebtcm_timer_test.sv
// Self-checking testbench for the timer core: registers, count clocks, modes and pin
`timescale 1ns/1ps
`default_nettype none

module ebtcm_timer_test;
    import ebtcm_pkg::*;
    localparam int D = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic bwr = 1'b0;
    logic bval = 1'b0;
    logic rd = 1'b0;
    logic osc = 1'b0;
    logic [2:0] bsel = 3'h0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] cmp = 8'hFF;
    logic [7:0] rdata, cnt, prev, r;
    logic irq, tout, toe, ext, irq_q, tout_q, pin_lvl;
    int err_total = 0;
    int checks_done = 0;
    int seed = 41;
    int n, hi;

    always #25 clk = ~clk;

    ebtcm_timer uut (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WR(wr), .I_BIT_WR(bwr),
        .I_BIT_SEL(bsel), .I_BIT_VAL(bval), .I_WDATA(wdata), .I_RD(rd), .I_OSC_MODE(osc),
        .I_COMPARE_VALUE(cmp), .I_EXT_COUNT_PIN(ext), .O_RDATA(rdata), .O_COUNT_VALUE(cnt),
        .O_MATCH_IRQ(irq), .O_TIMER_OUT(tout), .O_TIMER_OE(toe)
    );
    ebtcm_pin_model pin (.i_clk(clk), .i_oe(toe), .i_out(tout), .o_ext(ext), .o_wire(pin_lvl));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic int exp_gap(input int code, input logic full);
        int e;
        e = (code == 15) ? 11 : code - 5;
        if (code == 4) begin
            return 1;
        end
        return 1 << (e + (full ? 0 : 1));
    endfunction : exp_gap

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic cyc(input int k);
        repeat (k) begin
            @(posedge clk);
            #D;
        end
    endtask : cyc

    // Each access leaves one idle cycle so a strobe never drops and rises in one step
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        cyc(1);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask : wr_reg

    task automatic bit_wr(input int b, input logic v);
        cyc(1);
        addr = ADDR_MODE_CTL;
        bsel = 3'(b);
        bval = v;
        bwr = 1'b1;
        cyc(1);
        bwr = 1'b0;
    endtask : bit_wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        cyc(1);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        chk("read data", rdata, exp);
    endtask : rd_chk

    task automatic setup(input logic [3:0] code, input logic o, input logic [7:0] mode);
        wr_reg(ADDR_MODE_CTL, 8'h00);
        wr_reg(ADDR_CLK_SEL, {4'h0, code});
        osc = o;
        wr_reg(ADDR_MODE_CTL, mode);
    endtask : setup

    task automatic gap(input int lim, output int k);
        logic [7:0] c0;
        c0 = cnt;
        k = 0;
        while (cnt === c0) begin
            cyc(1);
            k++;
            if (k > lim) begin
                err_total++;
                $display("ERROR timeout waiting for count");
                end_sim();
            end
        end
    endtask : gap

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        cyc(12);
        rst_n = 1'b1;
        chk("count", cnt, 0);
        chk("oe", toe, 0);
        rd_chk(ADDR_MODE_CTL, MODE_CTL_RESET);
        rd_chk(ADDR_CLK_SEL, CLK_SEL_RESET);
        rd_chk(16'hFF54, 8'h00);
        r = 8'($random(seed));
        wr_reg(ADDR_CLK_SEL, r);
        rd_chk(ADDR_CLK_SEL, {4'h0, r[3:0]});
        wr_reg(ADDR_CLK_SEL, 8'h00);
        bit_wr(BIT_OUT_GATE, 1'b1);
        bit_wr(BIT_FF_SET, 1'b1);
        rd_chk(ADDR_MODE_CTL, 8'h01);
        chk("oe ext", toe, 0);
        wr_reg(ADDR_CLK_SEL, 8'h05);
        cyc(2);
        chk("oe", toe, 1);
        chk("out set", tout, 1);
        chk("pin level", pin_lvl, 1);
        wr_reg(ADDR_MODE_CTL, 8'h05);
        cyc(2);
        chk("out reset", tout, 0);
        wr_reg(ADDR_MODE_CTL, 8'h09);
        wr_reg(ADDR_MODE_CTL, 8'h0D);
        cyc(2);
        chk("out both", tout, 1);
        wr_reg(ADDR_MODE_CTL, 8'h08);
        cyc(2);
        chk("oe off", toe, 0);
        // Every prescaled code in both oscillator modes; code 4 only where allowed
        for (int o = 0; o < 2; o++) begin
            for (int c = 4; c < 16; c++) begin
                if (c == 4 && o == 1) continue;
                setup(4'(c), o[0], 8'h80);
                gap(5000, n);
                gap(5000, n);
                chk("tick gap", n, exp_gap(c, o[0]));
            end
        end
        for (int k = 0; k < 3; k++) begin
            setup((k == 2) ? 4'h4 : 4'(k + 2), k == 2, 8'h80);
            cyc(40);
            chk("frozen", cnt, 0);
        end
        for (int v = 0; v < 2; v++) begin
            cmp = (8'($random(seed)) & 8'h07) | 8'h01;
            setup(4'h4, 1'b0, 8'h81 | 8'(v << 1));
            cyc(3);
            repeat (60) begin
                prev = cnt;
                irq_q = irq;
                tout_q = tout;
                cyc(1);
                chk("clear count", cnt, (prev == cmp) ? 8'h00 : 8'(prev + 8'h01));
                chk("match irq", irq, prev == cmp);
                chk("invert", tout ^ tout_q, irq_q & v[0]);
            end
        end
        for (int v = 0; v < 2; v++) begin
            cmp = 8'($random(seed));
            setup(4'h4, 1'b0, 8'hC1 | 8'(v << 1));
            cyc(4);
            hi = 0;
            repeat (256) begin
                prev = cnt;
                cyc(1);
                hi += int'(tout);
                chk("pwm count", cnt, 8'(prev + 8'h01));
                chk("pwm irq", irq, prev == cmp);
            end
            chk("pwm high", hi, v ? 256 - int'(cmp) : int'(cmp));
        end
        wr_reg(ADDR_MODE_CTL, 8'h00);
        cyc(1);
        chk("stopped", cnt, 0);
        cmp = 8'hFF;
        for (int c = 0; c < 2; c++) begin
            setup(4'(c), 1'b0, 8'h81);
            pin.pulse(5, 4);
            cyc(8);
            chk("ext count", cnt, 5);
            chk("ext oe", toe, 0);
        end
        wr_reg(ADDR_MODE_CTL, 8'h00);
        end_sim();
    end

    // A hang anywhere ends the run well inside the cycle budget
    initial begin
        #5000000;
        err_total++;
        $display("ERROR timeout of whole run");
        end_sim();
    end
endmodule : ebtcm_timer_test

`default_nettype wire
